// [hdl/lpss_pkg.sv]
// constants shared by the linear pixel scan sequencer and its sample memory
// assumes a 50 MHz system clock that oversamples the pixel clock pins
package lpss_pkg;

  // array geometry; a chained pair of sections uses 1536
  localparam int LPSS_PIXELS = 768;
  localparam int LPSS_DATA_W = 12;

  // clocks that hold the integrators in reset, counting the start edge
  localparam int LPSS_SETUP_CLOCKS = 18;
  // pixel clock edge that releases the integrators
  localparam int LPSS_RELEASE_EDGE = LPSS_SETUP_CLOCKS + 1;

  // system clock and charge transfer time
  localparam int LPSS_MCLK_PERIOD_NS = 20;
  localparam int LPSS_XFER_TIME_US = 20;
  // least time, so round up to whole cycles
  localparam int LPSS_XFER_CYCLES =
    (LPSS_XFER_TIME_US * 1000 + LPSS_MCLK_PERIOD_NS - 1) /
    LPSS_MCLK_PERIOD_NS;

  localparam int LPSS_INTEG_W = 32;

  // sequencer states, one-hot
  typedef enum logic [2:0] {
    LPSS_IDLE = 3'b001,
    LPSS_SCAN = 3'b010,
    LPSS_XFER = 3'b100
  } lpss_state_t;

endpackage

// [hdl/lpss_sample_mem.sv]
// two-bank store of pixel samples: one bank held for readout, one filling
// assumes write and read come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module lpss_sample_mem #(
  parameter int ADDR_W = 11,
  parameter int DATA_W = 12
) (
  input wire logic i_mclk,
  input wire logic i_wr_en,
  input wire logic [ADDR_W-1:0] i_wr_addr,
  input wire logic [DATA_W-1:0] i_wr_data,
  input wire logic i_rd_en,
  input wire logic [ADDR_W-1:0] i_rd_addr,
  output logic [DATA_W-1:0] o_rd_data
);

  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // no reset on the array, so it maps onto block memory
  always_ff @(posedge i_mclk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
    if (i_rd_en) begin
      o_rd_data <= mem[i_rd_addr];
    end
  end

endmodule
`default_nettype wire

// [hdl/lpss_seq.sv]
// readout and integration sequencer of a clocked linear pixel array
// assumes start-of-scan, hold and pixel clock arrive as asynchronous pins
// and that the integrating front end streams samples in on i_mclk
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - integration runs from hold minus the eighteen setup clocks
// - start-of-scan high at a pixel clock rise begins a new scan
// - hold holds all samples at once, start shows pixel 1; each clock advances
// - integrators held in reset through clock 18, released on edge 19
// - first 18 pixels are read out while integrators are in reset
// - pixels 1-18 reconnect on clock 19; later ones the clock after readout
// - on clock n+1 last pixel reconnects and output goes high impedance
// - previous samples are read out while the next ones integrate
// - chained sections use a pixel count of 1536
module lpss_seq import lpss_pkg::*; #(
  parameter int PIXELS = LPSS_PIXELS, // 1536 when chained
  parameter int DATA_W = LPSS_DATA_W
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_start_scan,
  input wire logic i_hold,
  input wire logic i_pixel_clk,
  input wire logic i_px_wr_valid,
  input wire logic [$clog2(PIXELS)-1:0] i_px_wr_index,
  input wire logic [DATA_W-1:0] i_px_wr_data,
  output logic [DATA_W-1:0] o_analog_pixel_output,
  output logic o_output_enable,
  output logic [$clog2(PIXELS+2)-1:0] o_pixel_index,
  output logic o_integrator_reset_switch,
  output logic o_sample_select_switch,
  output logic o_reconnect_group,
  output logic [$clog2(PIXELS+2)-1:0] o_reconnect_index,
  output logic o_charge_transfer_done,
  output logic [LPSS_INTEG_W-1:0] o_integration_cycles
);

  localparam int PIX_W = $clog2(PIXELS);
  localparam int CNT_W = $clog2(PIXELS + 2);
  localparam int ADDR_W = PIX_W + 1;
  localparam int XFER_W = $clog2(LPSS_XFER_CYCLES + 1);
  localparam logic [CNT_W-1:0] LAST_EDGE = CNT_W'(PIXELS + 1);
  localparam logic [CNT_W-1:0] REL_EDGE = CNT_W'(LPSS_RELEASE_EDGE);
  localparam logic [CNT_W-1:0] GROUP_IDX = CNT_W'(LPSS_SETUP_CLOCKS);
  localparam logic [CNT_W-1:0] NPIX = CNT_W'(PIXELS);
  localparam logic [XFER_W-1:0] XFER_END = XFER_W'(LPSS_XFER_CYCLES);

  // bank bit on top, pixel index below
  function automatic logic [ADDR_W-1:0] mem_addr(input logic bank,
                                                 input logic [CNT_W-1:0] idx);
    mem_addr = {bank, idx[PIX_W-1:0]};
  endfunction

  // pin synchronisers; only the pixel clock keeps a third, delayed copy
  // for its edge detector, the level pins need just two stages
  logic [1:0] sos_sync;
  logic [1:0] hold_sync;
  logic [2:0] pclk_sync;

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      sos_sync <= 2'h0;
      hold_sync <= 2'h0;
      pclk_sync <= 3'h0;
    end else begin
      sos_sync <= {sos_sync[0], i_start_scan};
      hold_sync <= {hold_sync[0], i_hold};
      pclk_sync <= {pclk_sync[1:0], i_pixel_clk};
    end
  end

  lpss_state_t state;
  lpss_state_t next_state;
  logic [CNT_W-1:0] edge_cnt;
  logic [XFER_W-1:0] xfer_cnt;
  logic held_bank;
  logic integ_run;
  logic [LPSS_INTEG_W-1:0] integ_cnt;
  logic rd_pend;
  logic off_pend;
  logic [CNT_W-1:0] rd_idx_pend;
  logic [DATA_W-1:0] mem_rd_data;

  // pin events, all taken on a rising pixel clock edge
  wire pclk_rise = pclk_sync[1] & ~pclk_sync[2];
  wire scan_start = pclk_rise & sos_sync[1];
  wire hold_take = pclk_rise & hold_sync[1];
  wire scan_step = pclk_rise & ~sos_sync[1] & (state == LPSS_SCAN);
  wire [CNT_W-1:0] next_edge = scan_start ? CNT_W'(1) : edge_cnt + CNT_W'(1);
  wire edge_evt = scan_start | scan_step;

  // per-edge decode; edge k shows pixel k and edge n+1 ends the scan
  wire rd_go = edge_evt & (next_edge <= NPIX);
  wire release_evt = scan_step & (next_edge == REL_EDGE);
  wire late_recon = scan_step & (next_edge > REL_EDGE);
  wire scan_end = scan_step & (next_edge == LAST_EDGE);
  wire xfer_end = (state == LPSS_XFER) & (xfer_cnt == XFER_END);
  // hold swaps banks, so all pixels are held at one instant
  wire rd_bank = hold_take ? ~held_bank : held_bank;

  // the filling bank is the one not held, so readout overlaps integration
  // index widened to the count width so a power-of-two size cannot wrap
  wire wr_en = i_px_wr_valid & ~o_integrator_reset_switch &
               (CNT_W'(i_px_wr_index) < NPIX);
  wire [ADDR_W-1:0] wr_addr = mem_addr(~held_bank,
                                       CNT_W'(i_px_wr_index));
  wire [ADDR_W-1:0] rd_addr = mem_addr(rd_bank, next_edge - CNT_W'(1));

  lpss_sample_mem #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W)
  ) u_mem (
    .i_mclk(i_mclk),
    .i_wr_en(wr_en),
    .i_wr_addr(wr_addr),
    .i_wr_data(i_px_wr_data),
    .i_rd_en(rd_go),
    .i_rd_addr(rd_addr),
    .o_rd_data(mem_rd_data)
  );

  // a new start restarts from any state, even mid-scan
  always_comb begin
    next_state = state;
    case (state)
      LPSS_IDLE: begin
        if (scan_start) next_state = LPSS_SCAN;
      end
      LPSS_SCAN: begin
        if (scan_start) next_state = LPSS_SCAN;
        else if (scan_end) next_state = LPSS_XFER;
      end
      LPSS_XFER: begin
        if (scan_start) next_state = LPSS_SCAN;
        else if (xfer_end) next_state = LPSS_IDLE;
      end
      default: next_state = LPSS_IDLE;
    endcase
  end

  // sequence state, edge count and bank pointer
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= LPSS_IDLE;
      edge_cnt <= '0;
      held_bank <= 1'b0;
    end else begin
      state <= next_state;
      if (edge_evt) edge_cnt <= next_edge;
      if (hold_take) held_bank <= ~held_bank;
    end
  end

  // charge transfer timer after the last clock of a scan
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      xfer_cnt <= '0;
      o_charge_transfer_done <= 1'b0;
    end else begin
      if (state != LPSS_XFER || scan_start) xfer_cnt <= '0;
      else if (!xfer_end) xfer_cnt <= xfer_cnt + XFER_W'(1);
      if (scan_start) o_charge_transfer_done <= 1'b0;
      else if (xfer_end) o_charge_transfer_done <= 1'b1;
    end
  end

  // integrator reset from the start edge until edge 19
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_integrator_reset_switch <= 1'b0;
    end else if (scan_start) begin
      o_integrator_reset_switch <= 1'b1;
    end else if (release_evt) begin
      o_integrator_reset_switch <= 1'b0;
    end
  end

  // reconnect strobe: group 1-18 on edge 19, then pixel k-1 on edge k
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_sample_select_switch <= 1'b0;
      o_reconnect_group <= 1'b0;
      o_reconnect_index <= '0;
    end else begin
      o_sample_select_switch <= release_evt | late_recon;
      o_reconnect_group <= release_evt;
      if (release_evt) o_reconnect_index <= GROUP_IDX;
      else if (late_recon) o_reconnect_index <= next_edge - CNT_W'(1);
    end
  end

  // integration length in system clocks, release to hold, saturating
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      integ_run <= 1'b0;
      integ_cnt <= '0;
      o_integration_cycles <= '0;
    end else if (hold_take) begin
      o_integration_cycles <= integ_cnt;
      integ_run <= 1'b0;
      integ_cnt <= '0;
    end else begin
      if (release_evt) integ_run <= 1'b1;
      if (integ_run && integ_cnt != '1) integ_cnt <= integ_cnt + 1'b1;
    end
  end

  // read pipeline: memory answers one cycle after the edge event
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      rd_pend <= 1'b0;
      off_pend <= 1'b0;
      rd_idx_pend <= '0;
    end else begin
      rd_pend <= rd_go;
      off_pend <= scan_end;
      if (rd_go) rd_idx_pend <= next_edge;
    end
  end

  // output stage; high impedance shown by enable low and data zero
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_analog_pixel_output <= '0;
      o_output_enable <= 1'b0;
      o_pixel_index <= '0;
    end else if (rd_pend) begin
      o_analog_pixel_output <= mem_rd_data;
      o_output_enable <= 1'b1;
      o_pixel_index <= rd_idx_pend;
    end else if (off_pend) begin
      o_analog_pixel_output <= '0;
      o_output_enable <= 1'b0;
      o_pixel_index <= '0;
    end
  end

endmodule
`default_nettype wire

// [verif/lpss_seq_props.sv]
// port checks for the pixel scan sequencer, one mclk domain
// assumes bind from the bench onto lpss_seq
`timescale 1ns/1ps
`default_nettype none
module lpss_seq_props #(
  parameter int PIXELS = 768,
  parameter int DATA_W = 12
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic [DATA_W-1:0] o_analog_pixel_output,
  input wire logic o_output_enable,
  input wire logic [$clog2(PIXELS+2)-1:0] o_pixel_index,
  input wire logic o_integrator_reset_switch,
  input wire logic o_sample_select_switch,
  input wire logic o_reconnect_group,
  input wire logic [$clog2(PIXELS+2)-1:0] o_reconnect_index
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  // a released output must not show a stale pixel
  a_off_zero: assert property (
    !o_output_enable |-> o_pixel_index == 0 && o_analog_pixel_output == 0)
    else $error("output off but not cleared");
  a_on_range: assert property (
    o_output_enable |-> o_pixel_index >= 1 && o_pixel_index <= PIXELS)
    else $error("pixel number out of range");
  a_index_step: assert property (
    o_output_enable && $changed(o_pixel_index) && o_pixel_index != 1
    |-> o_pixel_index == $past(o_pixel_index) + 1)
    else $error("pixel skipped");
  a_first_pix: assert property (
    $rose(o_integrator_reset_switch) |=> o_output_enable && o_pixel_index == 1)
    else $error("scan did not show pixel 1");
  a_release_18: assert property (
    $fell(o_integrator_reset_switch) |-> o_pixel_index == 18)
    else $error("release not after 18 pixels");
  a_group_recon: assert property (
    $fell(o_integrator_reset_switch) |-> o_sample_select_switch &&
    o_reconnect_group && o_reconnect_index == 18)
    else $error("group reconnect missing");
  a_pulse_one: assert property (
    o_sample_select_switch |=> !o_sample_select_switch)
    else $error("reconnect strobe too long");
  a_recon_next: assert property (
    o_sample_select_switch && !o_reconnect_group && o_reconnect_index < PIXELS
    |=> o_pixel_index == o_reconnect_index + 1)
    else $error("reconnect not after readout");
  a_last_off: assert property (
    o_sample_select_switch && o_reconnect_index == PIXELS |=> !o_output_enable)
    else $error("output not released");
endmodule
`default_nettype wire

// [verif/lpss_ctrl_model.sv]
// controller model: one start/hold pulse, then n+1 pixel clocks
// assumes the bench pulses i_go only while o_busy is low
`timescale 1ns/1ps
`default_nettype none
module lpss_ctrl_model #(
  parameter int PIXELS = 24
) (
  input wire logic i_mclk,
  input wire logic i_go,
  output logic o_start,
  output logic o_hold,
  output logic o_pclk,
  output logic o_busy
);
  // hold shares the start pin, the usual wiring
  assign o_hold = o_start;
  // 4 mclk half period: 6.25 MHz, and wide enough for the pin sync
  initial begin
    o_start = 1'b0;
    o_pclk = 1'b0;
    o_busy = 1'b0;
    forever begin
      @(posedge i_mclk);
      if (i_go) begin
        o_busy <= 1'b1;
        o_start <= 1'b1;
        for (int r = 0; r <= PIXELS; r++) begin
          repeat (4) @(posedge i_mclk);
          o_pclk <= 1'b1;
          repeat (4) @(posedge i_mclk);
          o_pclk <= 1'b0;
          o_start <= 1'b0;
        end
        o_busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [verif/lpss_seq_bench.sv]
// bench for the pixel scan sequencer with a short array
// assumes the controller model owns the three pins
`timescale 1ns/1ps
`default_nettype none
module lpss_seq_bench;
  localparam int PIXELS = 24;
  logic mclk = 1'b0, rstn = 1'b0, go = 1'b0, wr_v = 1'b0;
  logic [4:0] wr_i = 5'h00;
  logic [11:0] wr_d = 12'h000;
  logic [11:0] ana;
  logic start, hold, pclk, busy, oe, rst_sw, sel, grp, done;
  logic [4:0] pix, rec;
  logic [31:0] icyc;
  int n_mismatch = 0, checks = 0, cyc = 0, t19 = 0, t1 = 0;
  lpss_seq #(.PIXELS(PIXELS), .DATA_W(12)) dut (.i_mclk(mclk),
    .i_rstn(rstn), .i_start_scan(start), .i_hold(hold), .i_pixel_clk(pclk),
    .i_px_wr_valid(wr_v), .i_px_wr_index(wr_i), .i_px_wr_data(wr_d),
    .o_analog_pixel_output(ana), .o_output_enable(oe), .o_pixel_index(pix),
    .o_integrator_reset_switch(rst_sw), .o_sample_select_switch(sel),
    .o_reconnect_group(grp), .o_reconnect_index(rec),
    .o_charge_transfer_done(done), .o_integration_cycles(icyc));
  lpss_ctrl_model #(.PIXELS(PIXELS)) u_ctrl (.i_mclk(mclk), .i_go(go),
    .o_start(start), .o_hold(hold), .o_pclk(pclk), .o_busy(busy));
  always #10 mclk = ~mclk;
  task automatic stop_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // cycle count doubles as the hang limit; three scans need ~4000
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  // front-end writes land in the bank read after the next hold
  task automatic fill(input int base);
    for (int i = 0; i < PIXELS; i++) begin
      @(posedge mclk);
      wr_v <= 1'b1;
      wr_i <= 5'(i);
      wr_d <= 12'(base + i);
    end
    @(posedge mclk);
    wr_v <= 1'b0;
  endtask
  // a pixel must stay on the output up to the next clock rise
  task automatic scan(input int base, input bit dat);
    int e;
    @(posedge mclk);
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    for (int r = 1; r <= PIXELS + 1; r++) begin // r is the pixel clock number
      @(posedge pclk);
      if (r == 1) t1 = cyc;
      // release on clock 19 of the last scan up to this hold, in mclk
      e = t1 - t19;
      if (r == 2 && dat) cmp(32'(icyc > e - 3 && icyc < e + 3), 1, "integ");
      if (r >= 2) cmp(pix, r - 1, "index");
      if (r >= 2 && dat) cmp(ana, base + r - 2, "data");
      if (r == 19) cmp(rst_sw, 1, "reset held");
      if (r == 19) t19 = cyc;
      if (r == 20) cmp(rst_sw, 0, "not released");
    end
    repeat (990) @(posedge mclk);
    cmp(oe, 0, "output still on");
    cmp(done, 0, "transfer done early");
    repeat (20) @(posedge mclk);
    cmp(done, 1, "transfer done late");
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    scan(0, 1'b0);
    fill(12'h100);
    scan(12'h100, 1'b1);
    fill(12'h200);
    scan(12'h200, 1'b1);
    stop_test();
  end
endmodule
bind lpss_seq lpss_seq_props #(.PIXELS(PIXELS), .DATA_W(DATA_W)) u_props (
  .i_mclk(i_mclk), .i_rstn(i_rstn),
  .o_analog_pixel_output(o_analog_pixel_output),
  .o_output_enable(o_output_enable), .o_pixel_index(o_pixel_index),
  .o_integrator_reset_switch(o_integrator_reset_switch),
  .o_sample_select_switch(o_sample_select_switch),
  .o_reconnect_group(o_reconnect_group),
  .o_reconnect_index(o_reconnect_index));
`default_nettype wire
